// File: logic/asel_pkg.sv
// Constants and carrier types for the attenuator state-select control.
// Assumes one system clock plus a host-driven serial shift clock.
//
// Behaviour
// [R1] Select pins pick preset one to four
// [R2] Host may toggle only first select pin
// [R3] Host drives both select pins for four
// [R4] Presets written only through serial interface
// [R5] Select change applies preset without serial traffic
// [R6] Parallel bits enable 1,2,4,8,16 dB sections
// [R7] Host holds parallel bits low in serial
// [R8] Source select low parallel, high serial
// [R9] 28 bits MSB first, rising clock, frame low
// [R10] Frame rising edge latches presets and updates
// [R11] Word holds presets four..one, eight reserved
// [R12] Presets read zero until first serial load
package asel_pkg;

  localparam int unsigned ASEL_ATTEN_W = 5;
  localparam int unsigned ASEL_WORD_W  = 28;
  localparam int unsigned ASEL_RSVD_W  = 8;
  localparam int unsigned ASEL_PIN_W   = 9;

  localparam logic [4:0]  ASEL_PRESET_RST = 5'h00;
  localparam logic [4:0]  ASEL_ATTEN_RST  = 5'h00;
  localparam logic [27:0] ASEL_WORD_RST   = 28'h0000000;

  // Select pin codes, {state_b, state_a}
  localparam logic [1:0] ASEL_SEL_P1 = 2'h0;
  localparam logic [1:0] ASEL_SEL_P2 = 2'h1;
  localparam logic [1:0] ASEL_SEL_P3 = 2'h2;
  localparam logic [1:0] ASEL_SEL_P4 = 2'h3;

  // Serial word, first member is the first bit shifted in
  typedef struct packed {
    logic [4:0] preset4;
    logic [4:0] preset3;
    logic [4:0] preset2;
    logic [4:0] preset1;
    logic [7:0] rsvd;
  } asel_word_t;

  // Asynchronous control pins, grouped for one synchroniser
  typedef struct packed {
    logic       frame_b;
    logic       source_sel;
    logic       state_b;
    logic       state_a;
    logic [4:0] par_bits;
  } asel_pins_t;

  // Idle pin levels after reset: frame high, everything else low
  localparam asel_pins_t ASEL_PINS_RST = 9'h100;

endpackage : asel_pkg

// File: logic/asel_sync.sv
// Two-flop level synchroniser of configurable width.
// Assumes inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module asel_sync #(
  parameter int unsigned     WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_chk
    $error("asel_sync WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : asel_sync
`default_nettype wire

// File: logic/asel_top.sv
// Attenuator control: serial preset loading, state select, parallel bus.
// Assumes the host stops sclk while frame_b is high, and holds frame_b
// high for at least three mclk periods between frames.
`timescale 1ns/1ps
`default_nettype none
module asel_top
  import asel_pkg::*;
#(
  parameter int unsigned ATTEN_W = ASEL_ATTEN_W
) (
  input  wire logic               mclk,
  input  wire logic               rst_b,
  input  wire logic               sclk,
  input  wire logic               frame_b,
  input  wire logic               sdi,
  input  wire logic               state_a,
  input  wire logic               state_b,
  input  wire logic               control_source_select,
  input  wire logic [ATTEN_W-1:0] parallel_atten_bits,
  output logic      [ATTEN_W-1:0] atten_setting,
  output logic                    serial_loaded
);

  if (ATTEN_W != ASEL_ATTEN_W) begin : g_chk
    $error("asel_top ATTEN_W must equal the serial preset width");
  end

  // Link domain: shift register on the host clock
  asel_word_t shift_reg;

  always_ff @(posedge sclk) begin
    if (!frame_b) begin
      shift_reg <= {shift_reg[ASEL_WORD_W-2:0], sdi}; // R9 R11
    end
  end

  // Pin synchronisation into the system domain
  asel_pins_t pins_raw;
  asel_pins_t pins_q;

  always_comb begin
    pins_raw.frame_b    = frame_b;
    pins_raw.source_sel = control_source_select;
    pins_raw.state_b    = state_b;
    pins_raw.state_a    = state_a;
    pins_raw.par_bits   = parallel_atten_bits;
  end

  // Reset to idle pin levels, so no false frame edge follows reset
  asel_sync #(
    .WIDTH    (ASEL_PIN_W),
    .RST_VAL  (ASEL_PINS_RST)
  ) u_sync (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .async_in (pins_raw),
    .sync_out (pins_q)
  );

  // Frame end detection; sclk is idle, so shift_reg is stable here
  logic frame_prev_reg;
  logic frame_rise;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      frame_prev_reg <= 1'b1;
    end else begin
      frame_prev_reg <= pins_q.frame_b;
    end
  end

  assign frame_rise = pins_q.frame_b & ~frame_prev_reg;

  // Preset storage, written only by a completed serial frame
  logic [4:0] preset1_reg;
  logic [4:0] preset2_reg;
  logic [4:0] preset3_reg;
  logic [4:0] preset4_reg;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      preset1_reg <= ASEL_PRESET_RST; // R12
      preset2_reg <= ASEL_PRESET_RST; // R12
      preset3_reg <= ASEL_PRESET_RST; // R12
      preset4_reg <= ASEL_PRESET_RST; // R12
    end else if (frame_rise) begin
      preset1_reg <= shift_reg.preset1; // R4 R10 R11
      preset2_reg <= shift_reg.preset2; // R4 R10 R11
      preset3_reg <= shift_reg.preset3; // R4 R10 R11
      preset4_reg <= shift_reg.preset4; // R4 R10 R11
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      serial_loaded <= 1'b0;
    end else if (frame_rise) begin
      serial_loaded <= 1'b1;
    end
  end

  // Preset chosen by the select pins
  logic [1:0] sel_code;
  logic [4:0] sel_val;

  assign sel_code = {pins_q.state_b, pins_q.state_a};

  always_comb begin
    unique case (sel_code)
      ASEL_SEL_P1: sel_val = preset1_reg; // R1
      ASEL_SEL_P2: sel_val = preset2_reg; // R1
      ASEL_SEL_P3: sel_val = preset3_reg; // R1
      ASEL_SEL_P4: sel_val = preset4_reg; // R1
    endcase
  end

  // Applied setting; bit n enables the 2**n dB section
  logic [4:0] atten_next;

  always_comb begin
    if (pins_q.source_sel) begin
      atten_next = sel_val; // R5 R8
    end else begin
      atten_next = pins_q.par_bits; // R6 R8
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      atten_setting <= ASEL_ATTEN_RST;
    end else begin
      atten_setting <= atten_next;
    end
  end

  // Checks
  property p_sel_p1;
    @(posedge mclk) disable iff (!rst_b)
    pins_q.source_sel && sel_code == 2'h0
      |=> atten_setting == $past(preset1_reg);
  endproperty
  a_sel_p1: assert property (p_sel_p1) // R1
    else $error("state 00 did not apply preset 1");

  property p_sel_p4;
    @(posedge mclk) disable iff (!rst_b)
    pins_q.source_sel && pins_q.state_a && pins_q.state_b
      |=> atten_setting == $past(preset4_reg);
  endproperty
  a_sel_p4: assert property (p_sel_p4) // R1
    else $error("state 11 did not apply preset 4");

  property p_sel_switch;
    @(posedge mclk) disable iff (!rst_b)
    pins_q.source_sel && $changed(sel_code) && !frame_rise
      |-> ##1 $stable(preset2_reg) && atten_setting == $past(sel_val);
  endproperty
  a_sel_switch: assert property (p_sel_switch) // R5
    else $error("select change did not switch preset directly");

  property p_par_path;
    @(posedge mclk) disable iff (!rst_b)
    !pins_q.source_sel |=> atten_setting == $past(pins_q.par_bits);
  endproperty
  a_par_path: assert property (p_par_path) // R6
    else $error("parallel bits not applied");

  property p_src_serial;
    @(posedge mclk) disable iff (!rst_b)
    pins_q.source_sel && pins_q.par_bits != sel_val
      |=> atten_setting != $past(pins_q.par_bits);
  endproperty
  a_src_serial: assert property (p_src_serial) // R8
    else $error("serial source followed the parallel bus");

  property p_shift;
    @(posedge sclk) disable iff (frame_b)
    1'b1 |=> shift_reg[0] == $past(sdi);
  endproperty
  a_shift: assert property (p_shift) // R9
    else $error("serial bit not captured on rising clock");

  property p_latch;
    @(posedge mclk) disable iff (!rst_b)
    frame_rise |=> preset4_reg == $past(shift_reg[27:23])
      && preset1_reg == $past(shift_reg[12:8]);
  endproperty
  a_latch: assert property (p_latch) // R10
    else $error("frame end did not latch presets");

  property p_latch_apply;
    @(posedge mclk) disable iff (!rst_b)
    frame_rise && pins_q.source_sel && sel_code == 2'h2
      ##1 pins_q.source_sel && sel_code == 2'h2
      |=> atten_setting == $past(shift_reg[22:18], 2);
  endproperty
  a_latch_apply: assert property (p_latch_apply) // R11
    else $error("preset 3 field misplaced in serial word");

  property p_hold;
    @(posedge mclk) disable iff (!rst_b)
    !frame_rise |=> $stable(preset3_reg) && $stable(preset4_reg);
  endproperty
  a_hold: assert property (p_hold) // R4
    else $error("preset changed without a serial frame");

  property p_zero;
    @(posedge mclk) disable iff (!rst_b)
    !serial_loaded |-> preset1_reg == 5'h00 && preset2_reg == 5'h00
      && preset3_reg == 5'h00 && preset4_reg == 5'h00;
  endproperty
  a_zero: assert property (p_zero) // R12
    else $error("preset nonzero before first load");

  c_load: cover property (@(posedge mclk) disable iff (!rst_b) frame_rise);
  c_p4: cover property (@(posedge mclk) disable iff (!rst_b)
    serial_loaded && pins_q.source_sel && sel_code == 2'h3);
  c_par: cover property (@(posedge mclk) disable iff (!rst_b)
    !pins_q.source_sel && pins_q.par_bits == 5'h1F);
  c_latch_p3: cover property (@(posedge mclk) disable iff (!rst_b)
    frame_rise && pins_q.source_sel && sel_code == 2'h2);

endmodule : asel_top
`default_nettype wire

// File: tb/asel_host_model.sv
// Host model: drives the three-wire preset link of the attenuator.
// Assumes the bench calls send only while the link is idle.
`timescale 1ns/1ps
`default_nettype none
module asel_host_model (
  output var logic sclk,
  output var logic frame_b,
  output var logic sdi
);
  initial begin
    sclk = 1'b0;
    frame_b = 1'b1;
    sdi = 1'b0;
  end

  // Clock stands still outside frames; data inverted once released
  task automatic send(input logic [27:0] w);
    frame_b = 1'b0;
    for (int i = 27; i >= 0; i--) begin
      sdi = w[i];
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
    #30 frame_b = 1'b1;
    sdi = ~sdi;
    #100;
  endtask : send
endmodule : asel_host_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the attenuator state-select control.
// Assumes asel_pkg, the design and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import asel_pkg::*;
  logic       mclk, rst_b, state_a, state_b, src, loaded;
  logic       sclk, frame_b, sdi;
  logic [4:0] par, atten;
  logic [4:0] p [4];
  int         failures, n_compared;

  asel_top i_asel_top (
    .mclk(mclk), .rst_b(rst_b), .sclk(sclk), .frame_b(frame_b),
    .sdi(sdi), .state_a(state_a), .state_b(state_b),
    .control_source_select(src), .parallel_atten_bits(par),
    .atten_setting(atten), .serial_loaded(loaded));

  asel_host_model i_asel_host_model (
    .sclk(sclk), .frame_b(frame_b), .sdi(sdi));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [4:0] e,
                     input logic [4:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic drive(input logic [1:0] sel, input logic s,
                       input logic [4:0] pb);
    @(posedge mclk);
    state_a <= sel[0];
    state_b <= sel[1];
    src <= s;
    par <= pb;
    repeat (6) @(posedge mclk);
    #1;
  endtask : drive

  // Arguments are presets one to four
  task automatic load(input logic [4:0] a, b, c, d);
    p[0] = a;
    p[1] = b;
    p[2] = c;
    p[3] = d;
    i_asel_host_model.send({d, c, b, a, 8'h00});
    repeat (6) @(posedge mclk);
    #1;
  endtask : load

  task automatic t_reset;
    drive(ASEL_SEL_P4, 1'b1, 5'h00);
    chk("atten", ASEL_PRESET_RST, atten);
    chk("loaded", 5'h00, {4'h0, loaded});
    $display("test reset done");
  endtask : t_reset

  task automatic t_parallel;
    for (int i = 0; i < 5; i++) begin
      drive(ASEL_SEL_P1, 1'b0, 5'h01 << i);
      chk("par", 5'h01 << i, atten);
    end
    drive(ASEL_SEL_P4, 1'b0, 5'h1F);
    chk("par", 5'h1F, atten);
    $display("test parallel done");
  endtask : t_parallel

  task automatic t_states;
    drive(ASEL_SEL_P3, 1'b1, 5'h00);
    load(5'h19, 5'h07, 5'h08, 5'h10);
    chk("loaded", 5'h01, {4'h0, loaded});
    chk("latch", p[2], atten);
    for (int s = 0; s < 4; s++) begin
      drive(s[1:0], 1'b1, 5'h00);
      chk("preset", p[s], atten);
    end
    drive(ASEL_SEL_P4, 1'b0, 5'h0A);
    chk("source", 5'h0A, atten);
    $display("test states done");
  endtask : t_states

  task automatic t_reload;
    drive(ASEL_SEL_P2, 1'b1, 5'h00);
    load(5'h03, 5'h1E, 5'h11, 5'h0C);
    chk("reload", 5'h1E, atten);
    // Only the first select pin moves
    for (int i = 0; i < 4; i++) begin
      drive({1'b0, i[0]}, 1'b1, 5'h00);
      chk("toggle", p[i % 2], atten);
    end
    $display("test reload done");
  endtask : t_reload

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  initial begin
    #100000;
    failures++;
    conclude();
  end

  initial begin
    failures = 0;
    n_compared = 0;
    rst_b = 1'b0;
    state_a = 1'b0;
    state_b = 1'b0;
    src = 1'b0;
    par = 5'h00;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_parallel();
    t_states();
    t_reload();
    conclude();
  end
endmodule : testbench
`default_nettype wire
